// ==== common/codec_regs_pkg.sv ====
package codec_regs_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // Register offsets
  localparam logic [7:0] ADDR_RESET_IDENT = 8'h00;
  localparam logic [7:0] ADDR_BIAS = 8'h04;
  localparam logic [7:0] ADDR_REFERENCE = 8'h05;
  localparam logic [7:0] ADDR_MIC_DETECT = 8'h06;
  localparam logic [7:0] ADDR_MIC_LEVEL = 8'h07;
  localparam logic [7:0] ADDR_ADC_OSR = 8'h0a;
  localparam logic [7:0] ADDR_INPUT_AMP = 8'h0c;

  // Field positions
  localparam int unsigned BIAS_ON_BIT = 0;
  localparam int unsigned REF_UNUSED_BUF_BIT = 6;
  localparam int unsigned REF_DIV_LSB = 1;
  localparam int unsigned REF_BUF_BIT = 0;
  localparam int unsigned MIC_CUR_THR_LSB = 4;
  localparam int unsigned MIC_SHORT_THR_LSB = 2;
  localparam int unsigned MIC_DET_BIT = 1;
  localparam int unsigned MIC_SUPPLY_BIT = 0;
  localparam int unsigned MIC_LEVEL_LSB = 0;
  localparam int unsigned ADC_OSR_BIT = 0;
  localparam int unsigned LEFT_AMP_BIT = 1;
  localparam int unsigned RIGHT_AMP_BIT = 0;

  // Reference divider modes
  typedef enum logic [1:0] {
    DIV_OFF = 2'h0,
    DIV_NORMAL = 2'h1,
    DIV_STANDBY = 2'h2,
    DIV_FAST_START = 2'h3
  } midrail_divider_type;

  // Values after reset
  localparam logic RST_BIAS_ON = 1'h0;
  localparam logic RST_REF_UNUSED_BUF = 1'h0;
  localparam midrail_divider_type RST_REF_DIV = DIV_OFF;
  localparam logic RST_REF_BUF = 1'h0;
  localparam logic [2:0] RST_MIC_CUR_THR = 3'h0;
  localparam logic [1:0] RST_MIC_SHORT_THR = 2'h0;
  localparam logic RST_MIC_DET = 1'h0;
  localparam logic RST_MIC_SUPPLY = 1'h0;
  localparam logic [2:0] RST_MIC_LEVEL = 3'h0;
  localparam logic RST_ADC_OSR = 1'h0;
  localparam logic RST_LEFT_AMP = 1'h0;
  localparam logic RST_RIGHT_AMP = 1'h0;

  // Highest distinct supply level code; codes above it alias to it
  localparam logic [2:0] MIC_LEVEL_TOP = 3'h4;

endpackage

// ==== core/codec_bias_power_regs.sv ====
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module codec_bias_power_regs #(
  // Arbitrary identification value
  parameter logic [15:0] IDENT_CODE = 16'h5a3c
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic [codec_regs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [codec_regs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [codec_regs_pkg::DATA_W-1:0] reg_rdata,
  // Analogue controls
  output logic master_current_gen_on,
  output logic midrail_unused_pin_buffer_on,
  output codec_regs_pkg::midrail_divider_type midrail_divider_select,
  output logic midrail_buffer_on,
  output logic [2:0] mic_current_threshold,
  output logic [1:0] mic_short_threshold,
  output logic mic_detect_on,
  output logic microphone_supply_on,
  output logic [2:0] microphone_supply_level,
  output logic [2:0] microphone_supply_ratio,
  output logic adc_high_oversample_select,
  output logic left_input_amp_on,
  output logic right_input_amp_on
);
  import codec_regs_pkg::*;

  // Write decode
  logic soft_reset;
  logic wr_bias;
  logic wr_reference;
  logic wr_mic_detect;
  logic wr_mic_level;
  logic wr_adc_osr;
  logic wr_input_amp;

  // Bias register
  logic bias_on_q;
  logic bias_on_d;

  // Reference register
  logic ref_unused_buf_q;
  logic ref_unused_buf_d;
  midrail_divider_type ref_div_q;
  midrail_divider_type ref_div_d;
  logic ref_buf_q;
  logic ref_buf_d;

  // Microphone supply detect register
  logic [2:0] mic_cur_thr_q;
  logic [2:0] mic_cur_thr_d;
  logic [1:0] mic_short_thr_q;
  logic [1:0] mic_short_thr_d;
  logic mic_det_q;
  logic mic_det_d;
  logic mic_supply_q;
  logic mic_supply_d;

  // Microphone supply level register
  logic [2:0] level_wr;
  logic [2:0] mic_level_q;
  logic [2:0] mic_level_d;
  logic [2:0] mic_ratio_q;
  logic [2:0] mic_ratio_d;

  // Converter register
  logic adc_osr_q;
  logic adc_osr_d;

  // Input amplifier register
  logic left_amp_q;
  logic left_amp_d;
  logic right_amp_q;
  logic right_amp_d;

  // Read path
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // The soft reset acts on the edge of the write itself, so the write data is never stored
  assign soft_reset = reg_write && (reg_addr == ADDR_RESET_IDENT);
  assign wr_bias = reg_write && (reg_addr == ADDR_BIAS);
  assign wr_reference = reg_write && (reg_addr == ADDR_REFERENCE);
  assign wr_mic_detect = reg_write && (reg_addr == ADDR_MIC_DETECT);
  assign wr_mic_level = reg_write && (reg_addr == ADDR_MIC_LEVEL);
  assign wr_adc_osr = reg_write && (reg_addr == ADDR_ADC_OSR);
  assign wr_input_amp = reg_write && (reg_addr == ADDR_INPUT_AMP);

  // Bias register
  always_comb begin
    bias_on_d = bias_on_q;
    if (soft_reset) begin
      bias_on_d = RST_BIAS_ON;
    end else if (wr_bias) begin
      bias_on_d = reg_wdata[BIAS_ON_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bias_on_q <= RST_BIAS_ON;
    end else begin
      bias_on_q <= bias_on_d;
    end
  end

  // Reference register
  always_comb begin
    ref_unused_buf_d = ref_unused_buf_q;
    ref_div_d = ref_div_q;
    ref_buf_d = ref_buf_q;
    if (soft_reset) begin
      ref_unused_buf_d = RST_REF_UNUSED_BUF;
      ref_div_d = RST_REF_DIV;
      ref_buf_d = RST_REF_BUF;
    end else if (wr_reference) begin
      ref_unused_buf_d = reg_wdata[REF_UNUSED_BUF_BIT];
      ref_div_d = midrail_divider_type'(reg_wdata[REF_DIV_LSB +: 2]);
      ref_buf_d = reg_wdata[REF_BUF_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ref_unused_buf_q <= RST_REF_UNUSED_BUF;
      ref_div_q <= RST_REF_DIV;
      ref_buf_q <= RST_REF_BUF;
    end else begin
      ref_unused_buf_q <= ref_unused_buf_d;
      ref_div_q <= ref_div_d;
      ref_buf_q <= ref_buf_d;
    end
  end

  // Microphone supply detect register
  always_comb begin
    mic_cur_thr_d = mic_cur_thr_q;
    mic_short_thr_d = mic_short_thr_q;
    mic_det_d = mic_det_q;
    mic_supply_d = mic_supply_q;
    if (soft_reset) begin
      mic_cur_thr_d = RST_MIC_CUR_THR;
      mic_short_thr_d = RST_MIC_SHORT_THR;
      mic_det_d = RST_MIC_DET;
      mic_supply_d = RST_MIC_SUPPLY;
    end else if (wr_mic_detect) begin
      mic_cur_thr_d = reg_wdata[MIC_CUR_THR_LSB +: 3];
      mic_short_thr_d = reg_wdata[MIC_SHORT_THR_LSB +: 2];
      mic_det_d = reg_wdata[MIC_DET_BIT];
      mic_supply_d = reg_wdata[MIC_SUPPLY_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mic_cur_thr_q <= RST_MIC_CUR_THR;
      mic_short_thr_q <= RST_MIC_SHORT_THR;
      mic_det_q <= RST_MIC_DET;
      mic_supply_q <= RST_MIC_SUPPLY;
    end else begin
      mic_cur_thr_q <= mic_cur_thr_d;
      mic_short_thr_q <= mic_short_thr_d;
      mic_det_q <= mic_det_d;
      mic_supply_q <= mic_supply_d;
    end
  end

  // Stored code reads back as written; the analogue side sees the saturated ratio
  assign level_wr = reg_wdata[MIC_LEVEL_LSB +: 3];

  always_comb begin
    mic_level_d = mic_level_q;
    mic_ratio_d = mic_ratio_q;
    if (soft_reset) begin
      mic_level_d = RST_MIC_LEVEL;
      mic_ratio_d = RST_MIC_LEVEL;
    end else if (wr_mic_level) begin
      mic_level_d = level_wr;
      // Saturating at write time keeps the alias codes off microphone_supply_ratio; microphone_supply_level carries the raw code
      if (level_wr >= MIC_LEVEL_TOP) begin
        mic_ratio_d = MIC_LEVEL_TOP;
      end else begin
        mic_ratio_d = level_wr;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mic_level_q <= RST_MIC_LEVEL;
      mic_ratio_q <= RST_MIC_LEVEL;
    end else begin
      mic_level_q <= mic_level_d;
      mic_ratio_q <= mic_ratio_d;
    end
  end

  // Converter register
  always_comb begin
    adc_osr_d = adc_osr_q;
    if (soft_reset) begin
      adc_osr_d = RST_ADC_OSR;
    end else if (wr_adc_osr) begin
      adc_osr_d = reg_wdata[ADC_OSR_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      adc_osr_q <= RST_ADC_OSR;
    end else begin
      adc_osr_q <= adc_osr_d;
    end
  end

  // Input amplifier register
  always_comb begin
    left_amp_d = left_amp_q;
    right_amp_d = right_amp_q;
    if (soft_reset) begin
      left_amp_d = RST_LEFT_AMP;
      right_amp_d = RST_RIGHT_AMP;
    end else if (wr_input_amp) begin
      left_amp_d = reg_wdata[LEFT_AMP_BIT];
      right_amp_d = reg_wdata[RIGHT_AMP_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      left_amp_q <= RST_LEFT_AMP;
      right_amp_q <= RST_RIGHT_AMP;
    end else begin
      left_amp_q <= left_amp_d;
      right_amp_q <= right_amp_d;
    end
  end

  // Only documented bits are placed; everything else stays zero
  always_comb begin
    rdata_d = '0;
    unique case (reg_addr)
      ADDR_RESET_IDENT: rdata_d = IDENT_CODE;
      ADDR_BIAS: rdata_d[BIAS_ON_BIT] = bias_on_q;
      ADDR_REFERENCE: begin
        rdata_d[REF_UNUSED_BUF_BIT] = ref_unused_buf_q;
        rdata_d[REF_DIV_LSB +: 2] = ref_div_q;
        rdata_d[REF_BUF_BIT] = ref_buf_q;
      end
      ADDR_MIC_DETECT: begin
        rdata_d[MIC_CUR_THR_LSB +: 3] = mic_cur_thr_q;
        rdata_d[MIC_SHORT_THR_LSB +: 2] = mic_short_thr_q;
        rdata_d[MIC_DET_BIT] = mic_det_q;
        rdata_d[MIC_SUPPLY_BIT] = mic_supply_q;
      end
      ADDR_MIC_LEVEL: rdata_d[MIC_LEVEL_LSB +: 3] = mic_level_q;
      ADDR_ADC_OSR: rdata_d[ADC_OSR_BIT] = adc_osr_q;
      ADDR_INPUT_AMP: begin
        rdata_d[LEFT_AMP_BIT] = left_amp_q;
        rdata_d[RIGHT_AMP_BIT] = right_amp_q;
      end
      default: rdata_d = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= '0;
    end else if (reg_read) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  // Outputs
  assign reg_rdata = rdata_q;
  assign master_current_gen_on = bias_on_q;
  assign midrail_unused_pin_buffer_on = ref_unused_buf_q;
  assign midrail_divider_select = ref_div_q;
  assign midrail_buffer_on = ref_buf_q;
  assign mic_current_threshold = mic_cur_thr_q;
  assign mic_short_threshold = mic_short_thr_q;
  assign mic_detect_on = mic_det_q;
  assign microphone_supply_on = mic_supply_q;
  assign microphone_supply_level = mic_level_q;
  assign microphone_supply_ratio = mic_ratio_q;
  assign adc_high_oversample_select = adc_osr_q;
  assign left_input_amp_on = left_amp_q;
  assign right_input_amp_on = right_amp_q;

endmodule // codec_bias_power_regs

// ==== tb/codec_bias_power_regs_asserts.sv ====
`timescale 1ns/1ps
module codec_bias_power_regs_asserts #(parameter logic [15:0] IDENT_CODE = 16'h5a3c) (
  // Clock, reset and register port
  input wire logic clk_sys, srst, reg_write, reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata,
  // Analogue controls
  input wire logic master_current_gen_on, midrail_unused_pin_buffer_on, midrail_buffer_on,
  input wire codec_regs_pkg::midrail_divider_type midrail_divider_select,
  input wire logic [2:0] mic_current_threshold, microphone_supply_level, microphone_supply_ratio,
  input wire logic [1:0] mic_short_threshold,
  input wire logic mic_detect_on, microphone_supply_on, adc_high_oversample_select,
  input wire logic left_input_amp_on, right_input_amp_on
);
  import codec_regs_pkg::*;
  wire logic [20:0] ctl = {master_current_gen_on, midrail_unused_pin_buffer_on, midrail_divider_select,
    midrail_buffer_on, mic_current_threshold, mic_short_threshold, mic_detect_on, microphone_supply_on,
    microphone_supply_level, microphone_supply_ratio, adc_high_oversample_select, left_input_amp_on,
    right_input_amp_on};
  wire logic mapped = reg_addr inside {ADDR_RESET_IDENT, ADDR_BIAS, ADDR_REFERENCE, ADDR_MIC_DETECT,
    ADDR_MIC_LEVEL, ADDR_ADC_OSR, ADDR_INPUT_AMP};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence wr_at(logic [7:0] a);
    reg_write && reg_addr == a;
  endsequence
  AST_SOFT_RESET: assert property (wr_at(ADDR_RESET_IDENT) |=> ctl == 21'h0) else $error("soft reset");
  AST_IDENT: assert property (reg_read && reg_addr == 8'h00 |=> reg_rdata == IDENT_CODE) else $error("id");
  AST_BIAS: assert property (wr_at(ADDR_BIAS) |=> ctl[20] == $past(reg_wdata[0])) else $error("bias");
  AST_REF: assert property (wr_at(ADDR_REFERENCE) |=> ctl[19:16] == {$past(reg_wdata[6]), $past(reg_wdata[2:0])})
    else $error("reference");
  AST_HW_RESET: assert property (disable iff (1'b0) srst |=> ctl == 21'h0 && reg_rdata == 16'h0000)
    else $error("hw reset");
  AST_LEVEL_RD: assert property (reg_read && reg_addr == ADDR_MIC_LEVEL |=> reg_rdata == {13'h0, ctl[8:6]})
    else $error("level read");
  AST_RD_IDLE: assert property (!reg_read |=> reg_rdata == 16'h0000) else $error("read idle");
  AST_MIC: assert property (wr_at(ADDR_MIC_DETECT) |=> ctl[15:9] == $past(reg_wdata[6:0])) else $error("mic");
  AST_RATIO: assert property (ctl[5:3] == (ctl[8:6] > 3'h3 ? MIC_LEVEL_TOP : ctl[8:6])) else $error("ratio");
  AST_OSR: assert property (wr_at(ADDR_ADC_OSR) |=> ctl[2] == $past(reg_wdata[0])) else $error("osr");
  AST_AMP: assert property (wr_at(ADDR_INPUT_AMP) |=> ctl[1:0] == $past(reg_wdata[1:0])) else $error("amp");
  AST_IGNORE: assert property (reg_write && !mapped |=> $stable(ctl)) else $error("stray write");
  AST_RD_HOLE: assert property (reg_read && !mapped |=> reg_rdata == 16'h0000) else $error("stray read");
endmodule // codec_bias_power_regs_asserts
bind codec_bias_power_regs codec_bias_power_regs_asserts #(.IDENT_CODE(IDENT_CODE)) u_asserts (.*);

// ==== tb/codec_bias_power_regs_test.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module codec_bias_power_regs_test;
  import codec_regs_pkg::*;
  localparam logic [15:0] ID = 16'h3c5a; // Arbitrary value
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  wire logic [15:0] reg_rdata;
  wire logic [20:0] ctl;
  int fail_count = 0;
  int samples_checked = 0;
  logic [7:0] addrs [6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0a, 8'h0c};
  logic [15:0] masks [6] = '{16'h0001, 16'h0047, 16'h007f, 16'h0007, 16'h0001, 16'h0003};
  always #25 clk_sys = ~clk_sys;
  codec_bias_power_regs #(.IDENT_CODE(ID)) dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .master_current_gen_on(ctl[20]), .midrail_unused_pin_buffer_on(ctl[19]), .midrail_divider_select(ctl[18:17]),
    .midrail_buffer_on(ctl[16]), .mic_current_threshold(ctl[15:13]), .mic_short_threshold(ctl[12:11]),
    .mic_detect_on(ctl[10]), .microphone_supply_on(ctl[9]), .microphone_supply_level(ctl[8:6]),
    .microphone_supply_ratio(ctl[5:3]), .adc_high_oversample_select(ctl[2]), .left_input_amp_on(ctl[1]),
    .right_input_amp_on(ctl[0]));
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata)
    @(posedge clk_sys);
    #1 `CHK("rdata idle", 16'h0000, reg_rdata)
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Whole run is about 165 cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    #1 `CHK("defaults", 21'h0, ctl)
    for (int i = 0; i < 6; i++) rd(addrs[i], 16'h0000);
    $display("test defaults done");
    for (int i = 0; i < 6; i++) begin
      wr(addrs[i], 16'hffff);
      rd(addrs[i], masks[i]);
    end
    `CHK("all on", 21'h1fffe7, ctl)
    wr(8'h01, 16'hffff);
    rd(8'h01, 16'h0000);
    `CHK("stray", 21'h1fffe7, ctl)
    rd(ADDR_RESET_IDENT, ID);
    wr(ADDR_RESET_IDENT, 16'h0000);
    `CHK("soft reset", 21'h0, ctl)
    rd(ADDR_REFERENCE, 16'h0000);
    $display("test access done");
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_MIC_LEVEL, {13'h0, c[2:0]});
      `CHK("ratio", (c > 3 ? 3'h4 : c[2:0]), ctl[5:3])
      rd(ADDR_MIC_LEVEL, {13'h0, c[2:0]});
      wr(ADDR_REFERENCE, {13'h0, c[1:0], 1'b0});
      `CHK("divider", c[1:0], ctl[18:17])
      wr(ADDR_ADC_OSR, {15'h0, c[0]});
      `CHK("osr", c[0], ctl[2])
      wr(ADDR_MIC_DETECT, {9'h0, c[2:0], c[1:0], c[0], ~c[0]});
      `CHK("mic", {c[2:0], c[1:0], c[0], ~c[0]}, ctl[15:9])
    end
    wr(ADDR_INPUT_AMP, 16'h0002);
    `CHK("amps", 2'b10, ctl[1:0])
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    #1 `CHK("srst", 21'h0, ctl)
    $display("test fields done");
    report_and_stop();
  end
endmodule // codec_bias_power_regs_test
